// >>> cpwt_map.svh
`ifndef CPWT_MAP_SVH
`define CPWT_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CPWT_ADDR_CTRL_LO    8'h00
`define CPWT_ADDR_CTRL_HI    8'h04
`define CPWT_ADDR_WIDTH_LO   8'h08
`define CPWT_ADDR_WIDTH_HI   8'h0c
`define CPWT_ADDR_PERIOD_LO  8'h10
`define CPWT_ADDR_PERIOD_HI  8'h14
`define CPWT_ADDR_IRQ_STAT   8'h18
`define CPWT_ADDR_IRQ_MASK   8'h1c
`define CPWT_ADDR_COUNT      8'h20

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define CPWT_INIT_BIT        7
`define CPWT_RUN_BIT         3
`define CPWT_MODE_HI         2
`define CPWT_MODE_LO         0
`define CPWT_SRC_HI          6
`define CPWT_SRC_LO          4
`define CPWT_SRC_EXT         3'h7
`define CPWT_EV_PERIOD       0
`define CPWT_EV_WIDTH        1
`define CPWT_NUM_EV          2
`define CPWT_WARM_LOW_BYTE   8'h00

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPWT_RST_BYTE        8'h00
`define CPWT_RST_WORD        16'h0000

`endif

// >>> cpwt_pkg.sv
package cpwt_pkg;

  typedef enum logic [2:0] {
    CPWT_MODE_PPG  = 3'b111,
    CPWT_MODE_WARM = 3'b101
  } cpwt_mode_t;

  typedef enum logic [0:0] {
    CPWT_ST_STOP = 1'b0,
    CPWT_ST_RUN  = 1'b1
  } cpwt_state_t;

endpackage

// >>> cpwt_tick_gen.sv
`timescale 1ns/1ps
`include "cpwt_map.svh"

module cpwt_tick_gen
  import cpwt_pkg::*;
#(
  parameter int unsigned PRE_W = 7
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] src_sel,
  input  wire logic       ext_count_input,
  output logic            tick_q
);

  if (PRE_W < 6)
  begin : g_bad
    $error("cpwt_tick_gen: PRE_W too small for divider select");
  end

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic [PRE_W-1:0] div_mask;
  logic             ext_q;
  logic             ext_d;
  logic             tick_d;

  // ----------------------------------------
  // Prescaler and source select
  // ----------------------------------------
  always_comb
  begin
    pre_d    = pre_q + PRE_W'(1);
    ext_d    = ext_count_input;
    div_mask = PRE_W'((1 << src_sel) - 1);
    if (src_sel == `CPWT_SRC_EXT)
      tick_d = ext_q & ~ext_count_input;
    else
      tick_d = ((pre_q & div_mask) == div_mask);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_q  <= '0;
      ext_q  <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q  <= pre_d;
      ext_q  <= ext_d;
      tick_q <= tick_d;
    end
  end

endmodule

// >>> cpwt_irq_ctl.sv
`timescale 1ns/1ps
`include "cpwt_map.svh"

module cpwt_irq_ctl
  import cpwt_pkg::*;
#(
  parameter int unsigned NUM_EV = `CPWT_NUM_EV
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [NUM_EV-1:0] events,
  input  wire logic              wr_stat,
  input  wire logic              wr_mask,
  input  wire logic [NUM_EV-1:0] wdata,
  output logic      [NUM_EV-1:0] status_q,
  output logic      [NUM_EV-1:0] mask_q,
  output logic                   irq_q
);

  if (NUM_EV < 1 || NUM_EV > 8)
  begin : g_bad
    $error("cpwt_irq_ctl: NUM_EV out of range");
  end

  logic [NUM_EV-1:0] status_d;
  logic [NUM_EV-1:0] mask_d;
  logic              irq_d;

  // ----------------------------------------
  // Sticky status, set wins over clear
  // ----------------------------------------
  always_comb
  begin
    status_d = wr_stat ? ((status_q & ~wdata) | events) : (status_q | events);
    mask_d   = wr_mask ? wdata : mask_q;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_q <= '0;
      mask_q   <= '0;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

endmodule

// >>> cpwt_timer.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cpwt_map.svh"

module cpwt_timer
  import cpwt_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned PRE_W = 7
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_input,
  output logic             pulse_out_pin_n,
  output logic             cascade_match_irq
);

  if (CNT_W != 16)
  begin : g_bad
    $error("cpwt_timer: CNT_W must be 16");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]             ctrl_lo_q;
  logic [7:0]             ctrl_lo_d;
  logic [7:0]             ctrl_hi_q;
  logic [7:0]             ctrl_hi_d;
  logic [7:0]             width_lo_q;
  logic [7:0]             width_lo_d;
  logic [7:0]             width_hi_q;
  logic [7:0]             width_hi_d;
  logic [7:0]             period_lo_q;
  logic [7:0]             period_lo_d;
  logic [7:0]             period_hi_q;
  logic [7:0]             period_hi_d;
  logic [CNT_W-1:0]       cnt_q;
  logic [CNT_W-1:0]       cnt_d;
  logic [CNT_W-1:0]       cnt_inc;
  logic                   output_flipflop_q;
  logic                   output_flipflop_d;
  logic                   pin_d;
  logic                   pready_d;
  logic                   pslverr_d;
  logic [31:0]            prdata_d;
  cpwt_state_t            state_q;
  cpwt_state_t            state_d;
  logic                   access;
  logic                   wr_en;
  logic                   mapped;
  logic                   wr_hi;
  logic                   run_q;
  logic                   new_run;
  logic                   is_ppg;
  logic                   is_warm;
  logic                   count_en;
  logic                   tick;
  logic [CNT_W-1:0]       width_val;
  logic [CNT_W-1:0]       period_val;
  logic                   width_hit;
  logic                   period_hit;
  logic [`CPWT_NUM_EV-1:0] events;
  logic [`CPWT_NUM_EV-1:0] irq_status;
  logic [`CPWT_NUM_EV-1:0] irq_mask;

  // ----------------------------------------
  // Source tick and interrupt blocks
  // ----------------------------------------
  cpwt_tick_gen #(
    .PRE_W (PRE_W)
  ) u_tick (
    .clk             (clk),
    .rst             (rst),
    .src_sel         (ctrl_lo_q[`CPWT_SRC_HI:`CPWT_SRC_LO]),
    .ext_count_input (ext_count_input),
    .tick_q          (tick)
  );

  cpwt_irq_ctl #(
    .NUM_EV (`CPWT_NUM_EV)
  ) u_irq (
    .clk      (clk),
    .rst      (rst),
    .events   (events),
    .wr_stat  (wr_en && paddr == `CPWT_ADDR_IRQ_STAT),
    .wr_mask  (wr_en && paddr == `CPWT_ADDR_IRQ_MASK),
    .wdata    (pwdata[`CPWT_NUM_EV-1:0]),
    .status_q (irq_status),
    .mask_q   (irq_mask),
    .irq_q    (cascade_match_irq)
  );

  // ----------------------------------------
  // Decode and match terms
  // ----------------------------------------
  always_comb
  begin
    access     = psel & penable & pready;
    wr_en      = access & pwrite;
    mapped     = (paddr == `CPWT_ADDR_CTRL_LO)   || (paddr == `CPWT_ADDR_CTRL_HI)   ||
                 (paddr == `CPWT_ADDR_WIDTH_LO)  || (paddr == `CPWT_ADDR_WIDTH_HI)  ||
                 (paddr == `CPWT_ADDR_PERIOD_LO) || (paddr == `CPWT_ADDR_PERIOD_HI) ||
                 (paddr == `CPWT_ADDR_IRQ_STAT)  || (paddr == `CPWT_ADDR_IRQ_MASK)  ||
                 (paddr == `CPWT_ADDR_COUNT);
    wr_hi      = wr_en && paddr == `CPWT_ADDR_CTRL_HI;
    run_q      = ctrl_hi_q[`CPWT_RUN_BIT];
    new_run    = pwdata[`CPWT_RUN_BIT];
    is_ppg     = ctrl_hi_q[`CPWT_MODE_HI:`CPWT_MODE_LO] == CPWT_MODE_PPG;
    is_warm    = ctrl_hi_q[`CPWT_MODE_HI:`CPWT_MODE_LO] == CPWT_MODE_WARM;
    count_en   = (state_q == CPWT_ST_RUN) && (is_ppg || is_warm);
    width_val  = {width_hi_q, width_lo_q};
    period_val = {period_hi_q, period_lo_q};
    cnt_inc    = cnt_q + CNT_W'(1);
    width_hit  = is_ppg && cnt_inc == width_val;
    if (is_warm)
      period_hit = cnt_inc == {period_hi_q, `CPWT_WARM_LOW_BYTE};
    else
      period_hit = cnt_inc == period_val;
    events                 = '0;
    events[`CPWT_EV_PERIOD] = count_en && tick && period_hit;
    events[`CPWT_EV_WIDTH]  = count_en && tick && width_hit && !period_hit;
  end

  // ----------------------------------------
  // Registers written by software
  // ----------------------------------------
  always_comb
  begin
    ctrl_lo_d   = ctrl_lo_q;
    ctrl_hi_d   = ctrl_hi_q;
    width_lo_d  = width_lo_q;
    width_hi_d  = width_hi_q;
    period_lo_d = period_lo_q;
    period_hi_d = period_hi_q;
    if (wr_en)
    begin
      unique case (paddr)
        `CPWT_ADDR_CTRL_LO:   ctrl_lo_d   = pwdata[7:0];
        `CPWT_ADDR_CTRL_HI:   ctrl_hi_d   = pwdata[7:0];
        `CPWT_ADDR_WIDTH_LO:  width_lo_d  = pwdata[7:0];
        `CPWT_ADDR_WIDTH_HI:  width_hi_d  = pwdata[7:0];
        `CPWT_ADDR_PERIOD_LO: period_lo_d = pwdata[7:0];
        `CPWT_ADDR_PERIOD_HI: period_hi_d = pwdata[7:0];
        default:              ctrl_lo_d   = ctrl_lo_q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_lo_q   <= `CPWT_RST_BYTE;
      ctrl_hi_q   <= `CPWT_RST_BYTE;
      width_lo_q  <= `CPWT_RST_BYTE;
      width_hi_q  <= `CPWT_RST_BYTE;
      period_lo_q <= `CPWT_RST_BYTE;
      period_hi_q <= `CPWT_RST_BYTE;
    end
    else
    begin
      ctrl_lo_q   <= ctrl_lo_d;
      ctrl_hi_q   <= ctrl_hi_d;
      width_lo_q  <= width_lo_d;
      width_hi_q  <= width_hi_d;
      period_lo_q <= period_lo_d;
      period_hi_q <= period_hi_d;
    end
  end

  // ----------------------------------------
  // Counter, output flip-flop and pin
  // ----------------------------------------
  always_comb
  begin
    state_d           = ctrl_hi_d[`CPWT_RUN_BIT] ? CPWT_ST_RUN : CPWT_ST_STOP;
    cnt_d             = cnt_q;
    output_flipflop_d = output_flipflop_q;
    unique case (state_q)
      CPWT_ST_STOP:
      begin
        cnt_d = `CPWT_RST_WORD;
      end
      CPWT_ST_RUN:
      begin
        if (count_en && tick)
        begin
          if (period_hit)
            cnt_d = `CPWT_RST_WORD;
          else
            cnt_d = cnt_inc;
          if (is_ppg && (period_hit ^ width_hit))
            output_flipflop_d = ~output_flipflop_q;
        end
      end
    endcase
    if (wr_hi && !run_q)
      output_flipflop_d = pwdata[`CPWT_INIT_BIT];
    pin_d = ~output_flipflop_d;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q           <= CPWT_ST_STOP;
      cnt_q             <= `CPWT_RST_WORD;
      output_flipflop_q <= 1'b0;
      pulse_out_pin_n   <= 1'b1;
    end
    else
    begin
      state_q           <= state_d;
      cnt_q             <= cnt_d;
      output_flipflop_q <= output_flipflop_d;
      pulse_out_pin_n   <= pin_d;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  always_comb
  begin
    pready_d  = psel && penable && !pready;
    pslverr_d = pready_d && !mapped;
    prdata_d  = '0;
    if (pready_d && !pwrite)
    begin
      unique case (paddr)
        `CPWT_ADDR_CTRL_LO:   prdata_d[7:0] = ctrl_lo_q;
        `CPWT_ADDR_CTRL_HI:   prdata_d[7:0] = ctrl_hi_q;
        `CPWT_ADDR_WIDTH_LO:  prdata_d[7:0] = width_lo_q;
        `CPWT_ADDR_WIDTH_HI:  prdata_d[7:0] = width_hi_q;
        `CPWT_ADDR_PERIOD_LO: prdata_d[7:0] = period_lo_q;
        `CPWT_ADDR_PERIOD_HI: prdata_d[7:0] = period_hi_q;
        `CPWT_ADDR_IRQ_STAT:  prdata_d[`CPWT_NUM_EV-1:0] = irq_status;
        `CPWT_ADDR_IRQ_MASK:  prdata_d[`CPWT_NUM_EV-1:0] = irq_mask;
        `CPWT_ADDR_COUNT:     prdata_d[CNT_W-1:0] = cnt_q;
        default:              prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_count_inc;
    count_en && tick && !period_hit |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1);
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("counter did not advance on tick");

  property p_width_toggle;
    is_ppg && count_en && tick && width_hit && !period_hit && !wr_hi
      |=> output_flipflop_q != $past(output_flipflop_q) && cnt_q != '0;
  endproperty
  a_width_toggle: assert property (p_width_toggle)
    else $error("width match did not toggle or cleared counter");

  property p_period_toggle;
    is_ppg && count_en && tick && period_hit && !width_hit && !wr_hi
      |=> output_flipflop_q != $past(output_flipflop_q) && cnt_q == '0
          && irq_status[`CPWT_EV_PERIOD];
  endproperty
  a_period_toggle: assert property (p_period_toggle)
    else $error("period match did not toggle, clear and flag");

  property p_init_load;
    wr_hi && !run_q |=> output_flipflop_q == $past(pwdata[`CPWT_INIT_BIT]);
  endproperty
  a_init_load: assert property (p_init_load)
    else $error("flip-flop did not take the init level");

  property p_pin_inverse;
    pulse_out_pin_n == !output_flipflop_q;
  endproperty
  a_pin_inverse: assert property (p_pin_inverse)
    else $error("pin is not inverse of flip-flop");

  property p_stop_hold;
    wr_hi && run_q && !new_run |=> ##1 (pulse_out_pin_n == $past(pulse_out_pin_n)) [*2];
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("pin changed on stop");

  property p_period_write;
    wr_en && paddr == `CPWT_ADDR_PERIOD_LO |=> period_lo_q == $past(pwdata[7:0]);
  endproperty
  a_period_write: assert property (p_period_write)
    else $error("compare write not effective at once");

  property p_warm_match;
    is_warm && count_en && tick && cnt_inc == {period_hi_q, `CPWT_WARM_LOW_BYTE}
      |=> cnt_q == '0 && irq_status[`CPWT_EV_PERIOD] ##1 cascade_match_irq == irq_mask[0];
  endproperty
  a_warm_match: assert property (p_warm_match)
    else $error("warm-up match mishandled");

  property p_stopped_zero;
    !run_q ##1 !run_q |-> cnt_q == '0;
  endproperty
  a_stopped_zero: assert property (p_stopped_zero)
    else $error("counter not held at zero while stopped");

endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "cpwt_map.svh"

module tb_top;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_count_input;
  logic        pulse_out_pin_n;
  logic        cascade_match_irq;
  int          err_count;
  int          check_count;
  int          cyc;
  int          tq[$];
  logic        last_pin;
  logic        ext_en;
  logic [1:0]  ediv;
  logic [31:0] seed;
  logic [31:0] rd;
  logic        er;

  cpwt_timer dut (
    .clk               (clk),
    .rst               (rst),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .ext_count_input   (ext_count_input),
    .pulse_out_pin_n   (pulse_out_pin_n),
    .cascade_match_irq (cascade_match_irq)
  );

  // ----------------------------------------
  // Clock, monitor, timeout
  // ----------------------------------------
  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    cyc      <= cyc + 1;
    last_pin <= pulse_out_pin_n;
    if (!rst && pulse_out_pin_n !== last_pin)
      tq.push_back(cyc);
    if (cyc > 40000)
    begin
      err_count = err_count + 1;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  // External source: each level held two clocks
  always @(posedge clk)
  begin
    ediv <= ediv + 2'h1;
    if (ext_en && ediv[0])
      ext_count_input <= ~ext_count_input;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n = n + 1;
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1, "apb answer");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read data");
  endtask

  task automatic set_cmp(input logic [15:0] w, input logic [15:0] p);
    wr(`CPWT_ADDR_WIDTH_LO, {24'h0, w[7:0]});
    wr(`CPWT_ADDR_WIDTH_HI, {24'h0, w[15:8]});
    wr(`CPWT_ADDR_PERIOD_LO, {24'h0, p[7:0]});
    wr(`CPWT_ADDR_PERIOD_HI, {24'h0, p[15:8]});
  endtask

  // Pulse run; u is clocks per tick
  task automatic run_ppg(input logic [2:0] src, input int w, input int p, input int u);
    int n;
    n = 0;
    wr(`CPWT_ADDR_CTRL_LO, {25'h0, src, 4'h0});
    set_cmp(w[15:0], p[15:0]);
    wr(`CPWT_ADDR_CTRL_HI, 32'h07);
    repeat (2) @(posedge clk);
    chk(pulse_out_pin_n, 1'b1, "init level 0");
    tq.delete();
    wr(`CPWT_ADDR_CTRL_HI, 32'h0f);
    while (tq.size() < 4 && n < 20000)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(tq.size() >= 4, 1'b1, "toggle count");
    if (tq.size() >= 4)
    begin
      chk(tq[1] - tq[0], (p - w) * u, "width to period");
      chk(tq[2] - tq[1], w * u, "period to width");
      chk(tq[3] - tq[1], p * u, "full period");
    end
    wr(`CPWT_ADDR_CTRL_HI, 32'h07);
    rdc(`CPWT_ADDR_COUNT, 32'h0);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int w;
    int p;
    int n;
    logic [7:0] regs[5];
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_count_input = 1'b1;
    ext_en = 1'b0;
    ediv = 2'h0;
    last_pin = 1'b1;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    seed = 32'h0000002f;
    regs = '{`CPWT_ADDR_CTRL_LO, `CPWT_ADDR_CTRL_HI, `CPWT_ADDR_IRQ_STAT,
             `CPWT_ADDR_IRQ_MASK, `CPWT_ADDR_COUNT};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk(pulse_out_pin_n, 1'b1, "pin after reset");
    chk(cascade_match_irq, 1'b0, "irq after reset");
    foreach (regs[i])
      rdc(regs[i], 32'h0);
    rdc(8'h24, 32'h0);
    chk(er, 1'b1, "unmapped error");
    wr(`CPWT_ADDR_IRQ_MASK, 32'h1);
    // Internal sources, random compares
    for (int s = 0; s < 3; s++)
    begin
      w = 1 + int'(xs() % 20);
      p = w + 2 + int'(xs() % 20);
      run_ppg(s[2:0], w, p, 1 << s);
    end
    // Status, mask and W1C
    rdc(`CPWT_ADDR_IRQ_STAT, 32'h3);
    chk(cascade_match_irq, 1'b1, "irq raised");
    wr(`CPWT_ADDR_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk(cascade_match_irq, 1'b0, "irq masked");
    wr(`CPWT_ADDR_IRQ_MASK, 32'h1);
    wr(`CPWT_ADDR_IRQ_STAT, 32'h1);
    @(posedge clk);
    rdc(`CPWT_ADDR_IRQ_STAT, 32'h2);
    chk(cascade_match_irq, 1'b0, "irq cleared");
    wr(`CPWT_ADDR_IRQ_STAT, 32'h2);
    // External count pin, fixed compares 2 and 5
    ext_en <= 1'b1;
    run_ppg(3'h7, 2, 5, 4);
    ext_en <= 1'b0;
    // Stop holds pin; later write sets it
    set_cmp(16'hfff0, 16'hfff8);
    wr(`CPWT_ADDR_CTRL_LO, 32'h0);
    wr(`CPWT_ADDR_CTRL_HI, 32'h87);
    @(posedge clk);
    chk(pulse_out_pin_n, 1'b0, "init level 1");
    wr(`CPWT_ADDR_CTRL_HI, 32'h8f);
    wr(`CPWT_ADDR_CTRL_HI, 32'h87);
    @(posedge clk);
    chk(pulse_out_pin_n, 1'b0, "hold on stop");
    wr(`CPWT_ADDR_CTRL_HI, 32'h07);
    @(posedge clk);
    chk(pulse_out_pin_n, 1'b1, "pin high after stop");
    // Warm-up: lower period byte ignored
    wr(`CPWT_ADDR_IRQ_STAT, 32'h3);
    wr(`CPWT_ADDR_PERIOD_LO, 32'h10 + (xs() % 240));
    wr(`CPWT_ADDR_PERIOD_HI, 32'h01);
    wr(`CPWT_ADDR_CTRL_HI, 32'h05);
    tq.delete();
    wr(`CPWT_ADDR_CTRL_HI, 32'h0d);
    n = 0;
    while (cascade_match_irq !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(n >= 255 && n <= 262, 1'b1, "warm-up wait");
    chk(tq.size(), 0, "warm-up pin quiet");
    wr(`CPWT_ADDR_CTRL_HI, 32'h05);
    rdc(`CPWT_ADDR_IRQ_STAT, 32'h1);
    rdc(`CPWT_ADDR_COUNT, 32'h0);
    print_verdict();
  end
endmodule
